// ==== rtl/digital_filter.v ====
// simple accumulating filter standing in for the decimation filter
// assumes modulator bits arrive synchronous to the clock
`timescale 1ns/100ps
`include "sdch_regs.vh"
module digital_filter
(
   input wire clk,
   input wire rst_n,
   input wire ce,
   input wire load,
   input wire [7:0] preload,
   input wire run,
   input wire mod_bit,
   output reg sample,
   output reg [`FILTER_WIDTH-1:0] result
);
   reg [`FILTER_WIDTH-1:0] acc_reg;
   reg [7:0] tick_reg;

   // preload seeds the accumulator; a sample is taken every sample period
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         acc_reg <= {`FILTER_WIDTH{1'b0}};
         tick_reg <= 8'h00;
         sample <= 1'b0;
         result <= {`FILTER_WIDTH{1'b0}};
      end
      else if (ce)
      begin
         sample <= 1'b0;
         if (load)
         begin
            acc_reg <= {24'h000000, preload};
            tick_reg <= 8'h00;
         end
         else if (run)
         begin
            acc_reg <= acc_reg + {{(`FILTER_WIDTH-1){1'b0}}, mod_bit};
            if (tick_reg == `SAMPLE_CYCLES - 1)
            begin
               tick_reg <= 8'h00;
               sample <= 1'b1;
               result <= acc_reg;
            end
            else
               tick_reg <= tick_reg + 8'h01;
         end
      end
   end
endmodule

// ==== rtl/sample_counter.v ====
// counts samples after a start and flags the sample that raises the first interrupt
// assumes a single clock and a sample strobe from the filter
`timescale 1ns/100ps
`include "sdch_regs.vh"
module sample_counter
(
   input wire clk,
   input wire rst_n,
   input wire ce,
   input wire restart,
   input wire sample,
   input wire [1:0] delay_sel,
   output reg report
);
   reg [2:0] count_reg;
   reg armed_reg;
   wire [2:0] needed;

   // 00 needs four samples, 11 only one
   assign needed = 3'h4 - {1'b0, delay_sel};

   // after the first report every sample reports
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         count_reg <= 3'h0;
         armed_reg <= 1'b0;
         report <= 1'b0;
      end
      else if (ce)
      begin
         report <= 1'b0;
         if (restart)
         begin
            count_reg <= 3'h0;
            armed_reg <= 1'b1;
         end
         else if (sample)
         begin
            if (armed_reg)
            begin
               if (count_reg + 3'h1 >= needed)
               begin
                  armed_reg <= 1'b0;
                  report <= 1'b1;
               end
               count_reg <= count_reg + 3'h1;
            end
            else
               report <= 1'b1;
         end
      end
   end
endmodule

// ==== rtl/sdch_regs.vh ====
// register offsets, field positions, reset values and timing counts for one converter channel
// assumes it is included by bare name from the channel design files
//
// Function
// - set the result-ready flag whenever a new conversion result arrives; the code sets it only from the delay-selected sample on
// - clear the flag on result read; software may also clear it by writing
// - writing one to start-conversion starts a conversion; zero starts none
// - group bit joins channel with next higher channel; ignored on last channel
// - delay field picks sample raising first interrupt: 00 fourth ... 11 first
// - input select: 0-4 external pairs, 5 supply/11, 6 temperature, 7 short
// - result register returns upper or lower filter half per half-select bit
`ifndef SDCH_REGS_VH
`define SDCH_REGS_VH

// register offsets (byte addresses on the plain register port)
`define ADDR_CHANNEL_CONTROL 4'h0
`define ADDR_INPUT_CONTROL 4'h4
`define ADDR_CONVERSION_RESULT 4'h8
`define ADDR_FILTER_PRELOAD 4'hc
`define ADDR_IRQ_STATUS 4'h1
`define ADDR_IRQ_MASK 4'h2
`define ADDR_WIDTH 4

// channel control fields
`define CC_GROUP_BIT 0
`define CC_START_BIT 1
`define CC_FLAG_BIT 2
`define CC_HALF_BIT 6
`define CC_RESET 8'h00

// input control fields
`define IC_PAIR_LSB 0
`define IC_GAIN_LSB 3
`define IC_DELAY_LSB 6
`define IC_RESET 8'h00
`define PRELOAD_RESET 8'h00

// input pair codes
`define PAIR_SUPPLY_DIV 3'h5
`define PAIR_TEMP 3'h6
`define PAIR_SHORT 3'h7

// interrupt status bits
`define IRQ_RESULT_BIT 0
`define IRQ_START_BIT 1

// filter and sampling
`define FILTER_WIDTH 32
`define SAMPLE_PERIOD_NS 256
`define SAMPLE_CYCLES (`SAMPLE_PERIOD_NS / 8)

`endif

// ==== rtl/sdch_top.v ====
// register logic of one sigma-delta converter channel with its filter and interrupt
// assumes a single 125 MHz clock, synchronous inputs and a non-waiting register master
//
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
`include "sdch_regs.vh"
module sdch_top
(
   input wire CLOCK,
   input wire RST_N,
   input wire CE,
   input wire [3:0] ADDR,
   input wire [15:0] WDATA,
   input wire WR,
   input wire RD,
   output reg [15:0] RDATA,
   input wire MOD_BIT,
   input wire LAST_CHANNEL,
   input wire GROUP_START_IN,
   output reg GROUP_START_OUT,
   output reg [2:0] GAIN,
   output reg [2:0] PAIR,
   output reg PAIR_EXTERNAL,
   output reg BUSY,
   output reg IRQ
);
   reg [7:0] cctl_reg;
   reg [7:0] inctl_reg;
   reg [7:0] preload_reg;
   reg [1:0] irq_status_reg;
   reg [1:0] irq_mask_reg;
   reg running_reg;
   reg start_pulse_reg;
   reg flag_next;
   reg [1:0] status_next;
   wire wr_cc;
   wire rd_result;
   wire start_req;
   wire sample;
   wire report;
   wire [`FILTER_WIDTH-1:0] filt_out;
   wire [15:0] result_view;
   wire group_now;

   assign wr_cc = WR && (ADDR == `ADDR_CHANNEL_CONTROL);
   assign rd_result = RD && (ADDR == `ADDR_CONVERSION_RESULT);
   // software start, or a grouped lower channel starting us
   assign start_req = (wr_cc && WDATA[`CC_START_BIT]) || GROUP_START_IN;
   // half-select picks which 16 bits software sees
   assign result_view = cctl_reg[`CC_HALF_BIT] ? filt_out[15:0] : filt_out[31:16];
   // a start written with the group bit must use the bit being written, not the stale one
   assign group_now = wr_cc ? WDATA[`CC_GROUP_BIT] : cctl_reg[`CC_GROUP_BIT];

   digital_filter u_filter
   (
      .clk(CLOCK),
      .rst_n(RST_N),
      .ce(CE),
      .load(start_pulse_reg),
      .preload(preload_reg),
      .run(running_reg),
      .mod_bit(MOD_BIT),
      .sample(sample),
      .result(filt_out)
   );

   sample_counter u_count
   (
      .clk(CLOCK),
      .rst_n(RST_N),
      .ce(CE),
      .restart(start_pulse_reg),
      .sample(sample),
      .delay_sel(inctl_reg[7:6]),
      .report(report)
   );

   // flag: hardware set wins over read clear and software clear
   always @*
   begin
      flag_next = cctl_reg[`CC_FLAG_BIT];
      if (rd_result)
         flag_next = 1'b0;
      if (wr_cc)
         flag_next = WDATA[`CC_FLAG_BIT];
      if (report)
         flag_next = 1'b1;
   end

   // sticky status with write-one-to-clear; events win the same cycle
   always @*
   begin
      status_next = irq_status_reg;
      if (WR && (ADDR == `ADDR_IRQ_STATUS))
         status_next = irq_status_reg & ~WDATA[1:0];
      if (report)
         status_next[`IRQ_RESULT_BIT] = 1'b1;
      if (start_pulse_reg)
         status_next[`IRQ_START_BIT] = 1'b1;
   end

   // register writes and conversion control
   always @(posedge CLOCK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         cctl_reg <= `CC_RESET;
         inctl_reg <= `IC_RESET;
         preload_reg <= `PRELOAD_RESET;
         irq_status_reg <= 2'h0;
         irq_mask_reg <= 2'h0;
         running_reg <= 1'b0;
         start_pulse_reg <= 1'b0;
      end
      else if (CE)
      begin
         start_pulse_reg <= start_req;
         if (wr_cc)
            cctl_reg <= {WDATA[7:3], flag_next, WDATA[1:0]};
         else
            cctl_reg[`CC_FLAG_BIT] <= flag_next;
         // start bit reads back while a conversion is running
         if (start_req)
         begin
            running_reg <= 1'b1;
            cctl_reg[`CC_START_BIT] <= 1'b1;
         end
         else if (wr_cc && !WDATA[`CC_START_BIT])
            running_reg <= 1'b0;
         if (WR && (ADDR == `ADDR_INPUT_CONTROL))
            inctl_reg <= WDATA[7:0];
         if (WR && (ADDR == `ADDR_FILTER_PRELOAD))
            preload_reg <= WDATA[7:0];
         if (WR && (ADDR == `ADDR_IRQ_MASK))
            irq_mask_reg <= WDATA[1:0];
         irq_status_reg <= status_next;
      end
   end

   // registered outputs: read data, group chaining, front-end controls, interrupt
   always @(posedge CLOCK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         RDATA <= 16'h0000;
         GROUP_START_OUT <= 1'b0;
         GAIN <= 3'h0;
         PAIR <= 3'h0;
         PAIR_EXTERNAL <= 1'b0;
         BUSY <= 1'b0;
         IRQ <= 1'b0;
      end
      else if (CE)
      begin
         RDATA <= 16'h0000;
         if (RD)
         begin
            case (ADDR)
               `ADDR_CHANNEL_CONTROL: RDATA <= {8'h00, cctl_reg};
               `ADDR_INPUT_CONTROL: RDATA <= {8'h00, inctl_reg};
               `ADDR_CONVERSION_RESULT: RDATA <= result_view;
               `ADDR_FILTER_PRELOAD: RDATA <= {8'h00, preload_reg};
               `ADDR_IRQ_STATUS: RDATA <= {14'h0000, irq_status_reg};
               `ADDR_IRQ_MASK: RDATA <= {14'h0000, irq_mask_reg};
               default: RDATA <= 16'h0000;
            endcase
         end
         // last channel never passes its start onward
         GROUP_START_OUT <= start_req && group_now && !LAST_CHANNEL;
         GAIN <= inctl_reg[5:3];
         PAIR <= inctl_reg[2:0];
         PAIR_EXTERNAL <= (inctl_reg[2:0] < `PAIR_SUPPLY_DIV);
         BUSY <= running_reg;
         IRQ <= |(status_next & irq_mask_reg);
      end
   end
endmodule

// ==== verif/sdch_top_asserts.sv ====
// assertions for one converter channel, watching only its top ports
// assumes a bind onto sdch_top and one clock domain
`timescale 1ns/100ps
module sdch_top_asserts
(
   input logic CLOCK,
   input logic RST_N,
   input logic CE,
   input logic [3:0] ADDR,
   input logic [15:0] WDATA,
   input logic WR,
   input logic RD,
   input logic [15:0] RDATA,
   input logic LAST_CHANNEL,
   input logic GROUP_START_IN,
   input logic GROUP_START_OUT,
   input logic [2:0] PAIR,
   input logic PAIR_EXTERNAL,
   input logic BUSY
);
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (!RST_N);
   // accepted writes, decoded once
   wire wr_cc = CE && WR && ADDR == 4'h0;
   wire wr_ic = CE && WR && ADDR == 4'h4;
   wire go = wr_cc && WDATA[1];
   property p_start;
      go |-> ##[1:2] BUSY;
   endproperty
   a_start: assert property (p_start) else $error("start write left busy low");
   property p_stop;
      wr_cc && !WDATA[1] && !GROUP_START_IN ##1 !go && !GROUP_START_IN |-> ##1 !BUSY;
   endproperty
   a_stop: assert property (p_stop) else $error("busy high without start");
   property p_busy_cause;
      $rose(BUSY) |-> $past(go) || $past(go, 2) || $past(GROUP_START_IN) || $past(GROUP_START_IN, 2);
   endproperty
   a_busy_cause: assert property (p_busy_cause) else $error("busy rose with no start");
   property p_grp_fires;
      go && WDATA[0] && !LAST_CHANNEL |-> ##[1:2] GROUP_START_OUT;
   endproperty
   a_grp_fires: assert property (p_grp_fires) else $error("grouped start not passed on");
   property p_grp_last;
      GROUP_START_OUT |-> !LAST_CHANNEL;
   endproperty
   a_grp_last: assert property (p_grp_last) else $error("group start on last channel");
   property p_grp_cause;
      GROUP_START_OUT |-> $past(go) || $past(go, 2) || $past(GROUP_START_IN) || $past(GROUP_START_IN, 2);
   endproperty
   a_grp_cause: assert property (p_grp_cause) else $error("group start with no start");
   property p_pair;
      wr_ic ##1 !wr_ic |-> ##1 PAIR == $past(WDATA[2:0], 2) && PAIR_EXTERNAL == ($past(WDATA[2:0], 2) < 3'h5);
   endproperty
   a_pair: assert property (p_pair) else $error("input pair outputs wrong");
   property p_rdata;
      RDATA != 16'h0000 |-> $past(RD && CE);
   endproperty
   a_rdata: assert property (p_rdata) else $error("read data outside read slot");
endmodule

// ==== verif/tb.sv ====
// self-checking bench for one converter channel over its register port
// assumes the design and checker files are compiled first
`timescale 1ns/100ps
module tb;
   logic CLOCK = 1'b0, RST_N = 1'b0, CE = 1'b1, WR = 1'b0, RD = 1'b0, MOD_BIT = 1'b0;
   logic LAST_CHANNEL = 1'b0, GROUP_START_IN = 1'b0, GROUP_START_OUT, PAIR_EXTERNAL, BUSY, IRQ, g;
   logic [3:0] ADDR = 4'h0;
   logic [15:0] WDATA = 16'h0000, RDATA, v;
   logic [2:0] GAIN, PAIR;
   int n_mismatch = 0, checks = 0, n, i;
   sdch_top u_sdch_top (.CLOCK(CLOCK), .RST_N(RST_N), .CE(CE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
      .RDATA(RDATA), .MOD_BIT(MOD_BIT), .LAST_CHANNEL(LAST_CHANNEL), .GROUP_START_IN(GROUP_START_IN),
      .GROUP_START_OUT(GROUP_START_OUT), .GAIN(GAIN), .PAIR(PAIR), .PAIR_EXTERNAL(PAIR_EXTERNAL),
      .BUSY(BUSY), .IRQ(IRQ));
   always #4 CLOCK = ~CLOCK;
   // one-cycle strobes, launched right after an edge
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge CLOCK);
      WR <= 1'b1;
      ADDR <= a;
      WDATA <= d;
      @(posedge CLOCK);
      WR <= 1'b0;
   endtask
   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge CLOCK);
      RD <= 1'b1;
      ADDR <= a;
      @(posedge CLOCK);
      RD <= 1'b0;
      #1 d = RDATA;
   endtask
   task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
      checks++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask
   // group output seen in any of the next four cycles
   task automatic grp_seen();
      g = 1'b0;
      repeat (4)
      begin
         #1 g = g | GROUP_START_OUT;
         @(posedge CLOCK);
      end
   endtask
   task automatic results();
      $display("comparisons %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // main sequence: reset values, input select, delay and result, grouping
   initial
   begin
      repeat (10) @(posedge CLOCK);
      RST_N <= 1'b1;
      for (i = 0; i < 5; i++)
      begin
         rd(i == 0 ? 4'h0 : i == 1 ? 4'h4 : i == 2 ? 4'hc : i == 3 ? 4'h3 : 4'h1, v);
         chk("reset value", v, 16'h0000);
      end
      $display("test reset done");
      for (i = 0; i < 8; i++)
      begin
         wr(4'h4, {8'h00, 2'(i), 3'(7 - i), 3'(i)});
         rd(4'h4, v);
         chk("input control", v, {8'h00, 2'(i), 3'(7 - i), 3'(i)});
         chk("pair", {13'h0000, PAIR}, 16'(i));
         chk("gain", {13'h0000, GAIN}, 16'(7 - i));
         chk("external", {15'h0000, PAIR_EXTERNAL}, 16'(i < 5));
      end
      $display("test input select done");
      wr(4'hc, 16'h00a5);
      wr(4'h2, 16'h0001);
      for (i = 0; i < 4; i++)
      begin
         wr(4'h1, 16'h0003);
         wr(4'h4, {8'h00, 2'(i), 6'h00});
         wr(4'h0, 16'h0042);
         n = 0;
         while (IRQ !== 1'b1 && n < 400)
         begin
            @(posedge CLOCK);
            #1 n++;
         end
         // a timeout counts as a mismatch before the verdict
         if (n == 400)
         begin
            n_mismatch++;
            results();
         end
         chk("first irq sample", 16'((n + 16) / 32), 16'(4 - i));
         wr(4'h0, 16'h0044);
         rd(4'h8, v);
         chk("low half", v, 16'h00a5);
         rd(4'h0, v);
         chk("flag after read", v, 16'h0040);
      end
      rd(4'h1, v);
      chk("status", v, 16'h0003);
      wr(4'h1, 16'h0003);
      rd(4'h1, v);
      chk("status cleared", v, 16'h0000);
      chk("irq low", {15'h0000, IRQ}, 16'h0000);
      wr(4'h0, 16'h0004);
      rd(4'h0, v);
      chk("flag written", v, 16'h0004);
      rd(4'h8, v);
      chk("high half", v, 16'h0000);
      wr(4'h0, 16'h0004);
      wr(4'h0, 16'h0000);
      rd(4'h0, v);
      chk("software clear", v, 16'h0000);
      $display("test delay and result done");
      wr(4'h0, 16'h0003);
      grp_seen();
      chk("group out", {15'h0000, g}, 16'h0001);
      chk("busy", {15'h0000, BUSY}, 16'h0001);
      wr(4'h0, 16'h0000);
      LAST_CHANNEL <= 1'b1;
      wr(4'h0, 16'h0003);
      grp_seen();
      chk("group on last", {15'h0000, g}, 16'h0000);
      wr(4'h0, 16'h0000);
      repeat (3) @(posedge CLOCK);
      chk("busy stopped", {15'h0000, BUSY}, 16'h0000);
      GROUP_START_IN <= 1'b1;
      @(posedge CLOCK);
      GROUP_START_IN <= 1'b0;
      repeat (3) @(posedge CLOCK);
      chk("group in start", {15'h0000, BUSY}, 16'h0001);
      $display("test grouping done");
      results();
   end
endmodule
bind sdch_top sdch_top_asserts u_sdch_top_asserts (.CLOCK(CLOCK), .RST_N(RST_N), .CE(CE), .ADDR(ADDR),
   .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .LAST_CHANNEL(LAST_CHANNEL), .GROUP_START_IN(GROUP_START_IN),
   .GROUP_START_OUT(GROUP_START_OUT), .PAIR(PAIR), .PAIR_EXTERNAL(PAIR_EXTERNAL), .BUSY(BUSY));
